// ===== logic/sksf_pkg.sv
package sksf_pkg;
	// socket register offsets (byte addresses in the socket block)
	localparam logic [7:0] SKSF_OFS_PROTO = 8'h00;
	localparam logic [7:0] SKSF_OFS_CMD   = 8'h01;
	localparam logic [7:0] SKSF_OFS_FLAGS = 8'h02;
	localparam logic [7:0] SKSF_OFS_STATE = 8'h03;
	localparam logic [7:0] SKSF_OFS_PORTH = 8'h04;
	localparam logic [7:0] SKSF_OFS_PORTL = 8'h05;
	localparam logic [7:0] SKSF_OFS_MASK  = 8'h2c;
	// event flag bit positions
	localparam int SKSF_BIT_CON  = 0;
	localparam int SKSF_BIT_DISC = 1;
	localparam int SKSF_BIT_RECEIVE_FLAG = 2;
	localparam int SKSF_BIT_TOUT = 3;
	localparam int SKSF_BIT_SEND = 4;
	localparam logic [7:0] SKSF_FLAG_USED = 8'h1f;
	// reset values
	localparam logic [7:0]  SKSF_RST_FLAGS = 8'h00;
	localparam logic [7:0]  SKSF_RST_MASK  = 8'hff;
	localparam logic [15:0] SKSF_RST_PORT  = 16'h0000;
	// protocol field codes
	localparam logic [3:0] SKSF_PROTO_STREAM = 4'h1;
	localparam logic [3:0] SKSF_PROTO_DGRAM  = 4'h2;
	localparam logic [3:0] SKSF_PROTO_RAW    = 4'h4;
	// command codes
	localparam logic [7:0] SKSF_CMD_OPEN    = 8'h01;
	localparam logic [7:0] SKSF_CMD_LISTEN  = 8'h02;
	localparam logic [7:0] SKSF_CMD_CONNECT = 8'h04;
	localparam logic [7:0] SKSF_CMD_DISCONNECT_FLAG  = 8'h08;
	localparam logic [7:0] SKSF_CMD_CLOSE   = 8'h10;
	localparam logic [7:0] SKSF_CMD_SEND    = 8'h20;
	// state codes
	localparam logic [7:0] SKSF_ST_RELEASED = 8'h00;
	localparam logic [7:0] SKSF_ST_OPENED   = 8'h13;
	localparam logic [7:0] SKSF_ST_LISTEN   = 8'h14;
	localparam logic [7:0] SKSF_ST_REQSENT  = 8'h15;
	localparam logic [7:0] SKSF_ST_REQRECV  = 8'h16;
	localparam logic [7:0] SKSF_ST_CONN     = 8'h17;
	localparam logic [7:0] SKSF_ST_CLWAIT   = 8'h18;
	localparam logic [7:0] SKSF_ST_CLBOTH   = 8'h1a;
	localparam logic [7:0] SKSF_ST_LINGER   = 8'h1b;
	localparam logic [7:0] SKSF_ST_HALF     = 8'h1c;
	localparam logic [7:0] SKSF_ST_LASTACK  = 8'h1d;
	localparam logic [7:0] SKSF_ST_DGRAM    = 8'h22;
	localparam logic [7:0] SKSF_ST_RAW      = 8'h42;
	// host controller command port offsets
	localparam logic [3:0] SKSF_HOFS_ADDR   = 4'h0;
	localparam logic [3:0] SKSF_HOFS_WDATA  = 4'h1;
	localparam logic [3:0] SKSF_HOFS_GO     = 4'h2;
	localparam logic [3:0] SKSF_HOFS_RDATA  = 4'h3;
	localparam logic [3:0] SKSF_HOFS_STATUS = 4'h4;
	localparam logic [1:0] SKSF_GO_WRITE = 2'h1;
	localparam logic [1:0] SKSF_GO_READ  = 2'h2;
endpackage : sksf_pkg

// ===== logic/sksf_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sksf_link_if;
	logic       wr_en;
	logic       rd_en;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport dev (input wr_en, input rd_en, input addr, input wdata, output rdata);
	modport host (output wr_en, output rd_en, output addr, output wdata, input rdata);
endinterface : sksf_link_if
`default_nettype wire

// ===== logic/sksf_state_fsm.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sksf_state_fsm
	import sksf_pkg::*;
#(
	parameter bit IS_SOCKET0 = 1'b1
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	// command from the register file
	input  wire logic       cmd_valid,
	input  wire logic [7:0] cmd_code,
	input  wire logic [3:0] proto,
	// protocol engine events
	input  wire logic       ev_syn,
	input  wire logic       ev_synack,
	input  wire logic       ev_fin,
	input  wire logic       ev_finack,
	input  wire logic       ev_rst,
	input  wire logic       ev_timeout,
	// state out
	output logic [7:0]      state_code,
	output logic            became_conn,
	output logic            timeout_hit
);
	typedef enum logic [3:0] {
		S_REL, S_OPEN, S_LISTEN, S_REQS, S_REQR, S_CONN, S_HALF,
		S_FINW, S_CLOS, S_LING, S_LACK, S_DGRAM, S_RAW
	} sksf_st_t;
	typedef struct packed {
		sksf_st_t st;
	} sksf_fsm_t;
	sksf_fsm_t s_reg, s_next;

	always_comb begin
		s_next = s_reg;
		if (cmd_valid && cmd_code == SKSF_CMD_OPEN) begin
			case (proto)
				SKSF_PROTO_STREAM: s_next.st = S_OPEN;
				SKSF_PROTO_DGRAM: s_next.st = S_DGRAM;
				SKSF_PROTO_RAW: s_next.st = IS_SOCKET0 ? S_RAW : s_reg.st;
				default: s_next.st = s_reg.st;
			endcase
		end else if (cmd_valid && cmd_code == SKSF_CMD_CLOSE) begin
			s_next.st = S_REL;
		end else if (ev_rst || ev_timeout) begin
			// reset or timeout releases any state
			s_next.st = S_REL;
		end else begin
			case (s_reg.st)
				S_OPEN: begin
					if (cmd_valid && cmd_code == SKSF_CMD_LISTEN)
						s_next.st = S_LISTEN;
					else if (cmd_valid && cmd_code == SKSF_CMD_CONNECT)
						s_next.st = S_REQS;
				end
				S_LISTEN: begin
					if (ev_timeout)
						s_next.st = S_REL;
					else if (ev_syn)
						s_next.st = S_REQR;
				end
				S_REQS: begin
					if (ev_timeout)
						s_next.st = S_REL;
					else if (ev_synack)
						s_next.st = S_CONN;
				end
				S_REQR: begin
					if (ev_timeout)
						s_next.st = S_REL;
					else if (ev_synack)
						s_next.st = S_CONN;
				end
				S_CONN: begin
					if (ev_timeout)
						s_next.st = S_REL;
					else if (cmd_valid && cmd_code == SKSF_CMD_DISCONNECT_FLAG)
						s_next.st = S_FINW;
					else if (ev_fin)
						s_next.st = S_HALF;
				end
				S_HALF: begin
					if (ev_timeout)
						s_next.st = S_REL;
					else if (cmd_valid && cmd_code == SKSF_CMD_DISCONNECT_FLAG)
						s_next.st = S_LACK;
				end
				S_FINW: begin
					if (ev_timeout || ev_finack)
						s_next.st = S_REL;
					else if (ev_fin)
						s_next.st = S_CLOS;
				end
				S_CLOS: begin
					if (ev_timeout)
						s_next.st = S_REL;
					else if (ev_finack)
						s_next.st = S_LING;
				end
				S_LING: begin
					if (ev_timeout || ev_finack)
						s_next.st = S_REL;
				end
				S_LACK: begin
					if (ev_timeout || ev_finack)
						s_next.st = S_REL;
				end
				default: s_next.st = s_reg.st;
			endcase
			if (cmd_valid && cmd_code == SKSF_CMD_DISCONNECT_FLAG
				&& !(s_reg.st == S_CONN || s_reg.st == S_HALF))
				s_next.st = S_REL;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			s_reg <= '{st: S_REL};
		else
			s_reg <= s_next;
	end

	always_comb begin
		case (s_reg.st)
			S_OPEN:   state_code = SKSF_ST_OPENED;
			S_LISTEN: state_code = SKSF_ST_LISTEN;
			S_REQS:   state_code = SKSF_ST_REQSENT;
			S_REQR:   state_code = SKSF_ST_REQRECV;
			S_CONN:   state_code = SKSF_ST_CONN;
			S_HALF:   state_code = SKSF_ST_HALF;
			S_FINW:   state_code = SKSF_ST_CLWAIT;
			S_CLOS:   state_code = SKSF_ST_CLBOTH;
			S_LING:   state_code = SKSF_ST_LINGER;
			S_LACK:   state_code = SKSF_ST_LASTACK;
			S_DGRAM:  state_code = SKSF_ST_DGRAM;
			S_RAW:    state_code = SKSF_ST_RAW;
			default:  state_code = SKSF_ST_RELEASED;
		endcase
	end

	assign became_conn = (s_next.st == S_CONN) && (s_reg.st != S_CONN);
	assign timeout_hit = ev_timeout;
endmodule : sksf_state_fsm
`default_nettype wire

// ===== logic/sksf_device.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - masked events set their flag
// - writing one clears that flag
// - bit four: send complete
// - bit three: either timeout
// - bit two: data received
// - bit one: peer fin or fin ack received
// - bit zero: once on connect
// - state code read only
// - released on disconnect_flag, close, timeout
// - stream open gives 0x13
// - host connects/listens only when opened
// - listen waits syn, timeout releases
// - connected after accept or connect
// - peer fin gives half closed
// - datagram open gives 0x22
// - raw frame open, socket zero only
// - request sent transient state
// - request received transient state
// - closing states end in released
// - final ack wait then released
// - host sets port before open
// - command 0x01 opens socket
// - command 0x08 runs disconnect
module sksf_device
	import sksf_pkg::*;
#(
	parameter bit IS_SOCKET0 = 1'b1
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// register link
	sksf_link_if.dev         link,
	// protocol engine events, one-cycle pulses
	input  wire logic        ev_send_done,
	input  wire logic        ev_resolution_timeout,
	input  wire logic        ev_retransmit_timeout,
	input  wire logic        ev_data_rx,
	input  wire logic        ev_syn,
	input  wire logic        ev_synack,
	input  wire logic        ev_fin,
	input  wire logic        ev_finack,
	input  wire logic        ev_rst,
	// settings toward the engine
	output logic [15:0]      socket_local_port,
	output logic [3:0]       socket_protocol_select,
	output logic [7:0]       command_pulse_code,
	output logic             command_pulse
);
	import sksf_pkg::*;

	typedef struct packed {
		logic [7:0]  flags;
		logic [7:0]  mask;
		logic [15:0] port;
		logic [3:0]  proto;
		logic [7:0]  cmd;
		logic        cmd_v;
		logic [7:0]  rdata;
	} sksf_dev_t;
	sksf_dev_t r_reg, r_next;

	logic [7:0] state_code;
	logic       became_conn;
	logic       timeout_hit;
	logic [7:0] ev_vec;
	logic       ev_timeout;

	assign ev_timeout = ev_resolution_timeout | ev_retransmit_timeout;

	logic [7:0] flag_clr;
	logic [7:0] flag_upd;
	assign flag_clr = (link.wr_en && link.addr == SKSF_OFS_FLAGS) ? link.wdata : 8'h00;
	for (genvar b = 0; b < 8; b++) begin : g_flag
		// reserved bits never latch, so software sees zeros there
		assign flag_upd[b] = SKSF_FLAG_USED[b]
			& ((ev_vec[b] & r_reg.mask[b]) | (r_reg.flags[b] & ~flag_clr[b]));
	end

	sksf_state_fsm #(.IS_SOCKET0(IS_SOCKET0)) u_fsm (
		.sys_clk    (sys_clk),
		.reset_n    (reset_n),
		.cmd_valid  (r_reg.cmd_v),
		.cmd_code   (r_reg.cmd),
		.proto      (r_reg.proto),
		.ev_syn     (ev_syn),
		.ev_synack  (ev_synack),
		.ev_fin     (ev_fin),
		.ev_finack  (ev_finack),
		.ev_rst     (ev_rst),
		.ev_timeout (ev_timeout),
		.state_code (state_code),
		.became_conn(became_conn),
		.timeout_hit(timeout_hit)
	);

	always_comb begin
		ev_vec = 8'h00;
		ev_vec[SKSF_BIT_SEND] = ev_send_done;
		ev_vec[SKSF_BIT_TOUT] = timeout_hit;
		ev_vec[SKSF_BIT_RECEIVE_FLAG] = ev_data_rx;
		ev_vec[SKSF_BIT_DISC] = ev_fin | ev_finack;
		ev_vec[SKSF_BIT_CON] = became_conn;
	end

	always_comb begin
		r_next = r_reg;
		r_next.cmd_v = 1'b0;
		r_next.rdata = 8'h00;
		if (link.wr_en) begin
			case (link.addr)
				SKSF_OFS_PROTO: r_next.proto = link.wdata[3:0];
				SKSF_OFS_CMD: begin
					r_next.cmd   = link.wdata;
					r_next.cmd_v = 1'b1;
				end
				SKSF_OFS_PORTH: r_next.port[15:8] = link.wdata;
				SKSF_OFS_PORTL: r_next.port[7:0] = link.wdata;
				SKSF_OFS_MASK:  r_next.mask = link.wdata & SKSF_FLAG_USED;
				default: r_next.cmd_v = 1'b0;
			endcase
		end
		r_next.flags = flag_upd;
		if (link.rd_en) begin
			case (link.addr)
				SKSF_OFS_PROTO: r_next.rdata = {4'h0, r_reg.proto};
				SKSF_OFS_FLAGS: r_next.rdata = r_reg.flags;
				SKSF_OFS_STATE: r_next.rdata = state_code;
				SKSF_OFS_PORTH: r_next.rdata = r_reg.port[15:8];
				SKSF_OFS_PORTL: r_next.rdata = r_reg.port[7:0];
				SKSF_OFS_MASK:  r_next.rdata = r_reg.mask;
				default:        r_next.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			r_reg <= '{flags: SKSF_RST_FLAGS, mask: SKSF_RST_MASK & SKSF_FLAG_USED,
				port: SKSF_RST_PORT, proto: 4'h0, cmd: 8'h00, cmd_v: 1'b0,
				rdata: 8'h00};
		end else begin
			r_reg <= r_next;
		end
	end

	assign link.rdata             = r_reg.rdata;
	assign socket_local_port      = r_reg.port;
	assign socket_protocol_select = r_reg.proto;
	assign command_pulse_code     = r_reg.cmd;
	assign command_pulse          = r_reg.cmd_v;
endmodule : sksf_device
`default_nettype wire

// ===== logic/sksf_host.sv
`timescale 1ns/1ps
`default_nettype none
module sksf_host
	import sksf_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// software port
	input  wire logic [3:0]  sw_addr,
	input  wire logic [7:0]  sw_wdata,
	input  wire logic        sw_wr,
	input  wire logic        sw_rd,
	output logic [7:0]       sw_rdata,
	// register link
	sksf_link_if.host        link
);
	import sksf_pkg::*;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
		logic       capture;
		logic [7:0] result;
		logic [7:0] last_state;
		logic [7:0] sw_rdata;
	} sksf_host_t;
	sksf_host_t h_reg, h_next;

	always_comb begin
		h_next = h_reg;
		h_next.wr = 1'b0;
		h_next.rd = 1'b0;
		h_next.capture = h_reg.rd;
		h_next.sw_rdata = 8'h00;
		if (h_reg.capture) begin
			h_next.result = link.rdata;
			if (h_reg.addr == SKSF_OFS_STATE)
				h_next.last_state = link.rdata;
		end
		if (sw_wr) begin
			case (sw_addr)
				SKSF_HOFS_ADDR:  h_next.addr = sw_wdata;
				SKSF_HOFS_WDATA: h_next.wdata = sw_wdata;
				SKSF_HOFS_GO: begin
					h_next.wr = sw_wdata[1:0] == SKSF_GO_WRITE;
					h_next.rd = sw_wdata[1:0] == SKSF_GO_READ;
				end
				default: h_next.wr = 1'b0;
			endcase
		end
		if (sw_rd) begin
			case (sw_addr)
				SKSF_HOFS_ADDR:   h_next.sw_rdata = h_reg.addr;
				SKSF_HOFS_WDATA:  h_next.sw_rdata = h_reg.wdata;
				SKSF_HOFS_RDATA:  h_next.sw_rdata = h_reg.result;
				SKSF_HOFS_STATUS: h_next.sw_rdata = h_reg.last_state;
				default:          h_next.sw_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			h_reg <= '0;
		else
			h_reg <= h_next;
	end

	// software sequences open/listen/connect per last state code read
	assign link.wr_en = h_reg.wr;
	assign link.rd_en = h_reg.rd;
	assign link.addr  = h_reg.addr;
	assign link.wdata = h_reg.wdata;
	assign sw_rdata   = h_reg.sw_rdata;
endmodule : sksf_host
`default_nettype wire

// ===== tb/sksf_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sksf_link_assertions
	import sksf_pkg::*;
(
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       reset_n,
	// link signals
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	import sksf_pkg::*;
	// mirrors of plain storage, so readback is judged against what was written
	logic [7:0] port_hi_reg;
	logic [7:0] port_lo_reg;
	logic [4:0] mask_reg;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			port_hi_reg <= 8'h00;
			port_lo_reg <= 8'h00;
			mask_reg    <= 5'h1f;
		end else if (wr_en) begin
			if (addr == SKSF_OFS_PORTH) port_hi_reg <= wdata;
			if (addr == SKSF_OFS_PORTL) port_lo_reg <= wdata;
			if (addr == SKSF_OFS_MASK) mask_reg <= wdata[4:0];
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	strobes_never_both_a: assert property (!(wr_en && rd_en))
		else $error("both link strobes high");
	rdata_idle_zero_a: assert property (!rd_en |=> rdata == 8'h00)
		else $error("read data not zero outside a read");
	flags_reserved_a: assert property (rd_en && addr == SKSF_OFS_FLAGS |=> rdata[7:5] == 3'h0)
		else $error("reserved flag bits set");
	state_code_legal_a: assert property (rd_en && addr == SKSF_OFS_STATE |=> rdata inside
		{8'h00, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h22, 8'h42})
		else $error("state code not a legal value");
	port_high_byte_a: assert property (rd_en && addr == SKSF_OFS_PORTH |=> rdata == $past(port_hi_reg))
		else $error("port high byte readback wrong");
	port_low_byte_a: assert property (rd_en && addr == SKSF_OFS_PORTL |=> rdata == $past(port_lo_reg))
		else $error("port low byte readback wrong");
	mask_readback_a: assert property (rd_en && addr == SKSF_OFS_MASK |=> rdata == {3'h0, $past(mask_reg)})
		else $error("event mask readback wrong");
	unmapped_read_zero_a: assert property (rd_en && !(addr inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
		8'h05, 8'h2c}) |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	cover property (rd_en && addr == SKSF_OFS_STATE ##1 rdata == SKSF_ST_CONN);
	cover property (wr_en && addr == SKSF_OFS_FLAGS);
	cover property (rd_en && addr == SKSF_OFS_PORTL ##1 rdata != 8'h00);
endmodule : sksf_link_assertions
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
	import sksf_pkg::*;
	logic        sys_clk;
	logic        reset_n;
	logic [3:0]  sw_addr;
	logic [7:0]  sw_wdata;
	logic        sw_wr;
	logic        sw_rd;
	logic [7:0]  sw_rdata;
	logic [8:0]  ev;
	logic [15:0] dev_port;
	logic [7:0]  exp_flags;
	logic [7:0]  pv;
	logic [3:0]  dev_proto;
	logic [7:0]  dev_cmd;
	logic        dev_cmd_v;
	int          n_cmds = 0;
	int          n_pulses = 0;
	logic [3:0]  protos [4] = '{4'h0, 4'h1, 4'h2, 4'h4};
	int          mismatches = 0;
	int          num_checks = 0;
	int          cycles = 0;
	sksf_link_if link();
	sksf_host u_sksf_host (.sys_clk(sys_clk), .reset_n(reset_n), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .link(link));
	sksf_device u_sksf_device (.sys_clk(sys_clk), .reset_n(reset_n), .link(link),
		.ev_send_done(ev[0]), .ev_resolution_timeout(ev[1]), .ev_retransmit_timeout(ev[2]),
		.ev_data_rx(ev[3]), .ev_syn(ev[4]), .ev_synack(ev[5]), .ev_fin(ev[6]),
		.ev_finack(ev[7]), .ev_rst(ev[8]), .socket_local_port(dev_port),
		.socket_protocol_select(dev_proto), .command_pulse_code(dev_cmd),
		.command_pulse(dev_cmd_v));
	sksf_link_assertions u_sksf_link_assertions (.sys_clk(sys_clk), .reset_n(reset_n),
		.wr_en(link.wr_en), .rd_en(link.rd_en), .addr(link.addr), .wdata(link.wdata),
		.rdata(link.rdata));
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize
	// one software access; a gap cycle follows so strobes never re-rise at one edge
	task automatic sw_op(input logic [3:0] a, input logic [7:0] d, input logic rd);
		@(posedge sys_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= !rd;
		sw_rd <= rd;
		@(posedge sys_clk);
		sw_wr <= 1'b0;
		sw_rd <= 1'b0;
	endtask : sw_op
	task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
		sw_op(SKSF_HOFS_ADDR, a, 1'b0);
		sw_op(SKSF_HOFS_WDATA, d, 1'b0);
		sw_op(SKSF_HOFS_GO, {6'h00, SKSF_GO_WRITE}, 1'b0);
		repeat (3) @(posedge sys_clk);
		if (a == SKSF_OFS_CMD) n_cmds++;
	endtask : dev_wr
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
		sw_op(SKSF_HOFS_ADDR, a, 1'b0);
		sw_op(SKSF_HOFS_GO, {6'h00, SKSF_GO_READ}, 1'b0);
		repeat (3) @(posedge sys_clk);
		sw_op(SKSF_HOFS_RDATA, 8'h00, 1'b1);
		#1;
		`CHK(nm, e, sw_rdata)
		if (a == SKSF_OFS_STATE) begin
			sw_op(SKSF_HOFS_STATUS, 8'h00, 1'b1);
			#1;
			`CHK("last state", e, sw_rdata)
		end
	endtask : rd_chk
	task automatic pulse(input int i);
		@(posedge sys_clk);
		ev <= 9'h001 << i;
		@(posedge sys_clk);
		ev <= 9'h000;
	endtask : pulse
	task automatic open_sock(input logic [3:0] p);
		dev_wr(SKSF_OFS_PROTO, {4'h0, p});
		dev_wr(SKSF_OFS_CMD, SKSF_CMD_OPEN);
		`CHK("proto", p, dev_proto)
		`CHK("cmd", SKSF_CMD_OPEN, dev_cmd)
	endtask : open_sock
	function automatic logic [7:0] open_code(input logic [3:0] p);
		case (p)
			SKSF_PROTO_STREAM: return SKSF_ST_OPENED;
			SKSF_PROTO_DGRAM: return SKSF_ST_DGRAM;
			SKSF_PROTO_RAW: return SKSF_ST_RAW;
			default: return SKSF_ST_RELEASED;
		endcase
	endfunction : open_code
	function automatic logic [7:0] w1c(input logic [7:0] f, input logic [7:0] w);
		return f & ~w & SKSF_FLAG_USED;
	endfunction : w1c
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// hang guard: the sequence needs well under two thousand cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (dev_cmd_v === 1'b1) n_pulses++;
		if (cycles == 8000) begin
			mismatches++;
			summarize();
		end
	end
	initial begin
		reset_n = 1'b0;
		sw_addr = 4'h0;
		sw_wdata = 8'h00;
		sw_wr = 1'b0;
		sw_rd = 1'b0;
		ev = 9'h000;
		exp_flags = 8'h00;
		void'($urandom(40));
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd_chk("flags", SKSF_OFS_FLAGS, 8'h00);
		rd_chk("state", SKSF_OFS_STATE, SKSF_ST_RELEASED);
		rd_chk("mask", SKSF_OFS_MASK, 8'h1f);
		rd_chk("porth", SKSF_OFS_PORTH, 8'h00);
		repeat (3) begin
			pv = 8'($urandom);
			dev_wr(SKSF_OFS_PORTH, pv);
			dev_wr(SKSF_OFS_PORTL, ~pv);
			rd_chk("porth", SKSF_OFS_PORTH, pv);
			rd_chk("portl", SKSF_OFS_PORTL, ~pv);
			`CHK("port", {pv, ~pv}, dev_port)
		end
		dev_wr(SKSF_OFS_STATE, SKSF_ST_OPENED);
		rd_chk("state", SKSF_OFS_STATE, SKSF_ST_RELEASED);
		rd_chk("unmapped", 8'h40, 8'h00);
		for (int k = 0; k < 4; k++) begin
			open_sock(protos[k]);
			rd_chk("state", SKSF_OFS_STATE, open_code(protos[k]));
			dev_wr(SKSF_OFS_CMD, SKSF_CMD_CLOSE);
			rd_chk("state", SKSF_OFS_STATE, SKSF_ST_RELEASED);
		end
		open_sock(SKSF_PROTO_STREAM);
		dev_wr(SKSF_OFS_CMD, SKSF_CMD_CONNECT);
		rd_chk("state", SKSF_OFS_STATE, SKSF_ST_REQSENT);
		pulse(5);
		rd_chk("state", SKSF_OFS_STATE, SKSF_ST_CONN);
		rd_chk("flags", SKSF_OFS_FLAGS, 8'h01);
		pulse(3);
		pulse(0);
		rd_chk("flags", SKSF_OFS_FLAGS, 8'h15);
		pv = 8'($urandom);
		dev_wr(SKSF_OFS_FLAGS, pv);
		rd_chk("flags", SKSF_OFS_FLAGS, w1c(8'h15, pv));
		dev_wr(SKSF_OFS_FLAGS, 8'hff);
		dev_wr(SKSF_OFS_MASK, 8'h1b);
		pulse(3);
		rd_chk("flags", SKSF_OFS_FLAGS, 8'h00);
		dev_wr(SKSF_OFS_MASK, 8'hff);
		pulse(6);
		rd_chk("state", SKSF_OFS_STATE, SKSF_ST_HALF);
		rd_chk("flags", SKSF_OFS_FLAGS, 8'h02);
		dev_wr(SKSF_OFS_CMD, SKSF_CMD_DISCONNECT_FLAG);
		rd_chk("state", SKSF_OFS_STATE, SKSF_ST_LASTACK);
		pulse(7);
		rd_chk("state", SKSF_OFS_STATE, SKSF_ST_RELEASED);
		dev_wr(SKSF_OFS_FLAGS, 8'hff);
		open_sock(SKSF_PROTO_STREAM);
		dev_wr(SKSF_OFS_CMD, SKSF_CMD_LISTEN);
		rd_chk("state", SKSF_OFS_STATE, SKSF_ST_LISTEN);
		pulse(4);
		rd_chk("state", SKSF_OFS_STATE, SKSF_ST_REQRECV);
		pulse(2);
		rd_chk("state", SKSF_OFS_STATE, SKSF_ST_RELEASED);
		rd_chk("flags", SKSF_OFS_FLAGS, 8'h08);
		dev_wr(SKSF_OFS_FLAGS, 8'hff);
		open_sock(SKSF_PROTO_STREAM);
		dev_wr(SKSF_OFS_CMD, SKSF_CMD_CONNECT);
		pulse(5);
		dev_wr(SKSF_OFS_CMD, SKSF_CMD_DISCONNECT_FLAG);
		rd_chk("state", SKSF_OFS_STATE, SKSF_ST_CLWAIT);
		pulse(6);
		rd_chk("state", SKSF_OFS_STATE, SKSF_ST_CLBOTH);
		pulse(7);
		rd_chk("state", SKSF_OFS_STATE, SKSF_ST_LINGER);
		pulse(1);
		rd_chk("state", SKSF_OFS_STATE, SKSF_ST_RELEASED);
		rd_chk("flags", SKSF_OFS_FLAGS, 8'h0b);
		dev_wr(SKSF_OFS_FLAGS, 8'hff);
		open_sock(SKSF_PROTO_DGRAM);
		pulse(1);
		rd_chk("state", SKSF_OFS_STATE, SKSF_ST_RELEASED);
		rd_chk("flags", SKSF_OFS_FLAGS, 8'h08);
		dev_wr(SKSF_OFS_FLAGS, 8'hff);
		open_sock(SKSF_PROTO_STREAM);
		dev_wr(SKSF_OFS_CMD, SKSF_CMD_CONNECT);
		pulse(5);
		pulse(8);
		rd_chk("state", SKSF_OFS_STATE, SKSF_ST_RELEASED);
		rd_chk("flags", SKSF_OFS_FLAGS, 8'h01);
		`CHK("cmd pulses", n_cmds, n_pulses)
		summarize();
	end
endmodule : testbench
`default_nettype wire
